//--- rtl/psf_top.sv
// Purpose: four cooperating sequencers with fault indicators and registers
// Assumes: supply monitor inputs synchronous to clk
// Notes: indicator bits active high, one means lit
`timescale 1ns/1ns
`default_nettype none
`include "psf_map.svh"
module psf_top
    import psf_pkg::*;
#(
    parameter int UP_CYCLES = `PSF_UP_TIME_US * `PSF_CLK_MHZ,
    parameter int DOWN_CYCLES = `PSF_DOWN_TIME_US * `PSF_CLK_MHZ,
    parameter int SHOW_CYCLES = `PSF_SHOW_TIME_US * `PSF_CLK_MHZ,
    parameter int RESTART_CYCLES = `PSF_RESTART_TIME_US * `PSF_CLK_MHZ
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supplies, four channels per sequencer
    input wire logic [15:0] supply_good,
    input wire logic [15:0] supply_over,
    output logic [15:0] supply_enable,
    // Commands and external faults
    input wire logic turn_on,
    input wire logic over_temp,
    input wire logic supervisor_fault,
    output logic shared_fault,
    // Indicators
    output logic [3:0] fault_type_bit_hi,
    output logic [3:0] fault_type_bit_lo,
    output logic [3:0] fault_source_bit_hi,
    output logic [3:0] fault_source_bit_lo,
    output logic over_temp_ind,
    output logic irq,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    psf_seq_if sif [4] ();
    logic [3:0] seq_fault;
    logic [3:0] seq_powered;
    logic [3:0] seq_valid;
    logic [15:0] codes;
    logic [15:0] enables;
    logic any_fault;
    logic ext_in;
    logic all_on;
    logic fault_edge;
    logic any_fault_q_r;
    logic [31:0] show_r;
    logic [31:0] wait_r;
    logic restart_r;
    logic cmd_en_r;
    logic show_always_r;
    logic [4:0] status_r;
    logic [4:0] mask_r;
    logic [4:0] events;
    logic [4:0] clr_bits;
    logic [4:0] mask_nxt;
    logic sw_on;
    logic show;
    logic wr_pulse;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_hit;
    logic wr_low;
    logic [3:0] show_gate;

    assign ext_in = over_temp || supervisor_fault;
    assign any_fault = |seq_fault || (ext_in && |enables);
    assign sw_on = turn_on && cmd_en_r && !restart_r;
    assign fault_edge = any_fault && !any_fault_q_r;
    assign all_on = &seq_powered;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_seq
            logic others;
            assign others = |(seq_fault & ~(4'h1 << g));
            assign sif[g].good = supply_good[4*g +: 4];
            assign sif[g].over = supply_over[4*g +: 4];
            assign sif[g].turn_on = sw_on;
            assign sif[g].ext_fault = others || ext_in;
            assign seq_fault[g] = sif[g].fault;
            assign seq_powered[g] = sif[g].powered;
            assign seq_valid[g] = sif[g].code_valid;
            assign codes[4*g +: 4] = sif[g].code;
            assign enables[4*g +: 4] = {4{sif[g].enable}};
            psf_sequencer #(
                .UP_CYCLES(UP_CYCLES),
                .DOWN_CYCLES(DOWN_CYCLES)
            ) u_seq (
                .clk(clk),
                .rst(rst),
                .sif(sif[g])
            );
        end
    endgenerate

    // Restart after a power fault, then show the held pattern
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            any_fault_q_r <= 1'b0;
            restart_r <= 1'b0;
            wait_r <= 32'h0;
            show_r <= 32'h0;
        end
        else
        begin
            any_fault_q_r <= any_fault;
            if (fault_edge)
            begin
                restart_r <= 1'b1;
                wait_r <= 32'h0;
            end
            else if (restart_r)
            begin
                wait_r <= wait_r + 32'h1;
                if (wait_r >= 32'(RESTART_CYCLES))
                begin
                    restart_r <= 1'b0;
                    show_r <= 32'(SHOW_CYCLES);
                end
            end
            else if (show_r != 32'h0)
                show_r <= show_r - 32'h1;
        end
    end

    assign show = (show_r != 32'h0) || show_always_r;
    assign show_gate = {4{show}} & seq_valid;

    // Indicator outputs, all registered
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_type_bit_hi <= 4'h0;
            fault_type_bit_lo <= 4'h0;
            fault_source_bit_hi <= 4'h0;
            fault_source_bit_lo <= 4'h0;
            over_temp_ind <= 1'b0;
            supply_enable <= 16'h0;
            shared_fault <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                fault_type_bit_hi[i] <= show_gate[i] & codes[4*i+3];
                fault_type_bit_lo[i] <= show_gate[i] & codes[4*i+2];
                fault_source_bit_hi[i] <= show_gate[i] & codes[4*i+1];
                fault_source_bit_lo[i] <= show_gate[i] & codes[4*i];
            end
            over_temp_ind <= over_temp;
            supply_enable <= enables;
            shared_fault <= any_fault;
            irq <= |(status_r & mask_r);
        end
    end

    // Events: fault, over-temp, all powered, restart done, show done
    assign events = {fault_edge, over_temp, all_on, restart_r && wait_r >= 32'(RESTART_CYCLES),
        show_r == 32'h1};
    assign wr_low = wr_pulse && wr_strb[0];
    assign clr_bits = (wr_low && wr_addr == `PSF_ADDR_STATUS) ? wr_data[4:0] : 5'h0;
    assign mask_nxt = (wr_low && wr_addr == `PSF_ADDR_MASK) ? wr_data[4:0] : mask_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_r <= 5'h0;
            mask_r <= 5'h0;
            cmd_en_r <= 1'b1;
            show_always_r <= 1'b0;
        end
        else
        begin
            status_r <= (status_r & ~clr_bits) | events;
            mask_r <= mask_nxt;
            if (wr_low && wr_addr == `PSF_ADDR_CTRL)
            begin
                cmd_en_r <= wr_data[0];
                show_always_r <= wr_data[1];
            end
        end
    end

    assign wr_hit = wr_addr == `PSF_ADDR_STATUS || wr_addr == `PSF_ADDR_MASK
        || wr_addr == `PSF_ADDR_CTRL;
    assign rd_hit = rd_addr == `PSF_ADDR_CODES || rd_addr == `PSF_ADDR_LIVE
        || rd_addr == `PSF_ADDR_STATUS || rd_addr == `PSF_ADDR_MASK || rd_addr == `PSF_ADDR_CTRL;
    assign rd_data = (rd_addr == `PSF_ADDR_STATUS) ? {27'h0, status_r}
        : (rd_addr == `PSF_ADDR_MASK) ? {27'h0, mask_r}
        : (rd_addr == `PSF_ADDR_CODES) ? {12'h0, seq_valid, codes}
        : (rd_addr == `PSF_ADDR_CTRL) ? {30'h0, show_always_r, cmd_en_r}
        : (rd_addr == `PSF_ADDR_LIVE) ? {24'h0, restart_r, over_temp, any_fault, seq_powered, sw_on}
        : 32'h0;

    psf_axil u_axil (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit),
        .wr_hit(wr_hit)
    );
endmodule // psf_top
`default_nettype wire

//--- rtl/psf_map.svh
// Purpose: constants for the power sequencer fault reporter
// Assumes: 50 MHz clock, AXI4-Lite register access
// Notes: offsets are byte addresses
`ifndef PSF_MAP_SVH
`define PSF_MAP_SVH
`define PSF_ADDR_STATUS 8'h00
`define PSF_ADDR_MASK 8'h04
`define PSF_ADDR_CODES 8'h08
`define PSF_ADDR_CTRL 8'h0C
`define PSF_ADDR_LIVE 8'h10
`define PSF_TYPE_SEQ 2'h3
`define PSF_TYPE_RST 2'h2
`define PSF_TYPE_CMD 2'h1
`define PSF_TYPE_EXT 2'h0
`define PSF_CH4_CODE 2'h0
`define PSF_UP_TIME_US 1000
`define PSF_DOWN_TIME_US 1000
`define PSF_SHOW_TIME_US 100000
`define PSF_RESTART_TIME_US 10000
`define PSF_CLK_MHZ 50
`define PSF_RESP_OKAY 2'h0
`define PSF_RESP_SLVERR 2'h2
`define PSF_NUM_EVENTS 5
`endif

//--- rtl/psf_pkg.sv
// Purpose: types for the power sequencer fault reporter
// Assumes: nothing
// Notes: shared by the top, interface and sequencer files
package psf_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_UP, ST_MON, ST_DOWN} psf_state_type;
    typedef struct packed {
        logic [1:0] kind;
        logic [1:0] src;
    } psf_code_type;
endpackage

//--- rtl/psf_seq_if.sv
// Purpose: links one sequencer to the top
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface psf_seq_if;
    import psf_pkg::*;
    logic [3:0] good;
    logic [3:0] over;
    logic turn_on;
    logic ext_fault;
    logic fault;
    logic enable;
    logic powered;
    psf_code_type code;
    logic code_valid;
    modport seq (input good, over, turn_on, ext_fault,
        output fault, enable, powered, code, code_valid);
    modport top (output good, over, turn_on, ext_fault,
        input fault, enable, powered, code, code_valid);
endinterface
`default_nettype wire

//--- rtl/psf_sequencer.sv
// Purpose: one four-channel supply sequencer with fault capture
// Assumes: inputs synchronous to clk
// Notes: channel index 0 is channel 1
`timescale 1ns/1ns
`default_nettype none
`include "psf_map.svh"
module psf_sequencer
    import psf_pkg::*;
#(
    parameter int UP_CYCLES = `PSF_UP_TIME_US * `PSF_CLK_MHZ,
    parameter int DOWN_CYCLES = `PSF_DOWN_TIME_US * `PSF_CLK_MHZ
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    psf_seq_if.seq sif
);
    psf_state_type state_r;
    psf_state_type state_nxt;
    logic [31:0] timer_r;
    psf_code_type code_r;
    logic valid_r;
    logic new_fault;
    psf_code_type new_code;
    logic [1:0] first_bad;
    logic [1:0] first_over;
    logic [1:0] first_low;
    logic all_good;
    logic up_late;
    logic any_over;
    logic any_low;
    logic cmd_drop;
    logic cmd_early;
    logic own_fault;

    assign all_good = &sif.good;
    assign any_over = |sif.over;
    assign any_low = ~all_good;
    assign up_late = (state_r == ST_UP) && !all_good && (timer_r >= 32'(UP_CYCLES));
    assign cmd_drop = (state_r == ST_UP) && !sif.turn_on;
    assign cmd_early = (state_r == ST_DOWN) && sif.turn_on;
    // Lowest failing channel; index 0 shows as code 11
    assign first_bad = !sif.good[0] ? 2'h3 : !sif.good[1] ? 2'h2 : !sif.good[2] ? 2'h1 : 2'h0;
    assign first_over = sif.over[0] ? 2'h3 : sif.over[1] ? 2'h2 : sif.over[2] ? 2'h1 : 2'h0;
    assign first_low = first_bad;
    // Faults raised here, not heard from the shared line
    assign own_fault = (state_r != ST_OFF && any_over) || up_late || cmd_drop || cmd_early
        || (state_r == ST_MON && any_low);

    always_comb
    begin
        new_fault = 1'b1;
        new_code = '{kind: `PSF_TYPE_EXT, src: `PSF_CH4_CODE};
        if (state_r != ST_OFF && any_over)
            new_code = '{kind: `PSF_TYPE_EXT, src: first_over};
        else if (up_late)
            new_code = '{kind: `PSF_TYPE_SEQ, src: first_bad};
        else if (state_r == ST_MON && any_low)
            new_code = '{kind: `PSF_TYPE_RST, src: first_low};
        else if (cmd_drop || cmd_early)
            new_code = '{kind: `PSF_TYPE_CMD, src: `PSF_CH4_CODE};
        else if (state_r != ST_OFF && sif.ext_fault)
            new_code = '{kind: `PSF_TYPE_EXT, src: `PSF_CH4_CODE};
        else
            new_fault = 1'b0;
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: if (sif.turn_on) state_nxt = ST_UP;
            ST_UP: if (new_fault) state_nxt = ST_DOWN;
                else if (all_good) state_nxt = ST_MON;
            ST_MON: if (new_fault || !sif.turn_on) state_nxt = ST_DOWN;
            ST_DOWN: if (timer_r >= 32'(DOWN_CYCLES)) state_nxt = ST_OFF;
            default: state_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_OFF;
            timer_r <= 32'h0;
            code_r <= '{kind: 2'h0, src: 2'h0};
            valid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            timer_r <= (state_nxt != state_r) ? 32'h0 : timer_r + 32'h1;
            if (state_r == ST_OFF && sif.turn_on)
                valid_r <= 1'b0;
            else if (new_fault && !valid_r)
            begin
                valid_r <= 1'b1;
                code_r <= new_code;
            end
        end
    end

    assign sif.fault = own_fault;
    assign sif.enable = (state_r == ST_UP) || (state_r == ST_MON);
    assign sif.powered = (state_r == ST_MON);
    assign sif.code = code_r;
    assign sif.code_valid = valid_r;
endmodule // psf_sequencer
`default_nettype wire

//--- rtl/psf_axil.sv
// Purpose: AXI4-Lite slave for the fault reporter registers
// Assumes: one write and one read at a time
// Notes: unmapped addresses answer SLVERR, read zero
`timescale 1ns/1ns
`default_nettype none
`include "psf_map.svh"
module psf_axil (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit,
    input wire logic wr_hit
);
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic do_read;

    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign wr_pulse = do_write;
    assign wr_addr = awaddr_r;
    assign wr_data = wdata_r;
    assign wr_strb = wstrb_r;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSF_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `PSF_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `PSF_RESP_OKAY : `PSF_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_data : 32'h0;
                s_axi_rresp <= rd_hit ? `PSF_RESP_OKAY : `PSF_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // psf_axil
`default_nettype wire

//--- testbench/psf_top_props.sv
// Purpose: port checks for psf_top
// Assumes: one clock domain
// Notes: bound into every psf_top
`timescale 1ns/1ns
`default_nettype none
module psf_top_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supplies and faults
    input wire logic [15:0] supply_good,
    input wire logic [15:0] supply_over,
    input wire logic [15:0] supply_enable,
    input wire logic turn_on,
    input wire logic over_temp,
    input wire logic shared_fault,
    input wire logic over_temp_ind,
    // Bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    wire logic up0 = &supply_enable[3:0] && !(&supply_good[3:0]);
    wire logic mon0 = &supply_enable[3:0] && &supply_good[3:0];
    wire logic ov = |(supply_over & supply_enable);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence in_mon_s;
        mon0 [*2];
    endsequence
    sequence sag_s;
        in_mon_s ##1 up0;
    endsequence
    sequence drop_s;
        $fell(turn_on) && up0 && $past(up0);
    endsequence
    ot_follow_a: assert property (over_temp_ind == $past(over_temp))
        else $error("over temperature indicator does not follow");
    ov_trip_a: assert property ($rose(ov) |-> ##[1:5] shared_fault)
        else $error("over voltage not spread");
    uv_trip_a: assert property (sag_s |-> ##[1:5] shared_fault)
        else $error("under voltage not tripped");
    drop_cmd_a: assert property (drop_s |-> ##[1:5] shared_fault)
        else $error("command drop not reported");
    temp_ext_a: assert property ($rose(over_temp) && mon0 |-> ##[1:5] shared_fault)
        else $error("over temperature not reported");
    off_stay_a: assert property (!turn_on && supply_enable == 16'h0000 |=> supply_enable == 16'h0000)
        else $error("supplies enabled without command");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule // psf_top_props
bind psf_top psf_top_props u_props (.clk(clk), .rst(rst), .supply_good(supply_good),
    .supply_over(supply_over), .supply_enable(supply_enable), .turn_on(turn_on),
    .over_temp(over_temp), .shared_fault(shared_fault), .over_temp_ind(over_temp_ind),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- testbench/psf_supply_model.sv
// Purpose: supply regulators behind the sequencer enables
// Assumes: good rises two cycles after enable rises and falls one cycle after it falls
// Notes: stuck, sag and over masks come from the bench
`timescale 1ns/1ns
`default_nettype none
module psf_supply_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Enables and injected faults
    input wire logic [15:0] enable,
    input wire logic [15:0] stuck,
    input wire logic [15:0] sag,
    input wire logic [15:0] over,
    // Monitor outputs
    output logic [15:0] good,
    output logic [15:0] over_v
);
    logic [15:0] ramp_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ramp_r <= 16'h0000;
            good <= 16'h0000;
        end
        else
        begin
            ramp_r <= enable;
            good <= ramp_r & enable & ~stuck & ~sag;
        end
    end
    // A disabled supply cannot go over-voltage
    assign over_v = over & enable;
endmodule // psf_supply_model
`default_nettype wire

//--- testbench/psf_top_tb.sv
// Purpose: self-checking bench for psf_top
// Assumes: short counts set by parameters
// Notes: codes read over the bus and on the indicators
`timescale 1ns/1ns
`default_nettype none
module psf_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic turn_on = 1'b0, otmp = 1'b0, svf = 1'b0;
    logic [15:0] stuck = 16'h0000, sag = 16'h0000, over = 16'h0000;
    logic [15:0] good, ovv, en;
    logic shf, oti, irq, awr, wr, bv, arr, rv;
    logic [3:0] th, tl, sh, sl;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [1:0] br, rr;
    int mismatches = 0, compares = 0;
    always #10 clk = ~clk;
    psf_top #(.UP_CYCLES(20), .DOWN_CYCLES(20), .SHOW_CYCLES(40), .RESTART_CYCLES(30)) dut (
        .clk(clk), .rst(rst), .supply_good(good), .supply_over(ovv), .supply_enable(en),
        .turn_on(turn_on), .over_temp(otmp), .supervisor_fault(svf), .shared_fault(shf),
        .fault_type_bit_hi(th), .fault_type_bit_lo(tl), .fault_source_bit_hi(sh),
        .fault_source_bit_lo(sl), .over_temp_ind(oti), .irq(irq),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry));
    psf_supply_model sup_m (.clk(clk), .rst(rst), .enable(en), .stuck(stuck), .sag(sag),
        .over(over), .good(good), .over_v(ovv));
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic need(input logic ok);
        chk(32'(ok), 32'h1);
        if (ok !== 1'b1)
            conclude();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (i = 0; i < 50 && bv !== 1'b1; i++)
        begin
            @(posedge clk);
            if (awr)
                awv <= 1'b0;
            if (wr)
                wv <= 1'b0;
        end
        bry <= 1'b0;
        need(bv);
        chk(32'(br), 32'(er));
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
        input logic [1:0] er);
        int i;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (i = 0; i < 50 && rv !== 1'b1; i++)
        begin
            @(posedge clk);
            if (arr)
                arv <= 1'b0;
        end
        rry <= 1'b0;
        need(rv);
        chk(rd & m, ed);
        chk(32'(rr), 32'(er));
        @(posedge clk);
    endtask
    task automatic up(input logic full);
        int i;
        turn_on <= 1'b1;
        for (i = 0; i < 100 && (full ? good !== 16'hFFFF : en !== 16'hFFFF); i++)
            @(posedge clk);
        need(full ? good === 16'hFFFF : en === 16'hFFFF);
        if (full)
            repeat (3) @(posedge clk);
    endtask
    task automatic flt(input string nm, input logic [31:0] cd, input logic [31:0] m);
        int i;
        logic [3:0] q;
        for (i = 0; i < 100 && shf !== 1'b1; i++)
            @(posedge clk);
        need(shf);
        turn_on <= 1'b0;
        repeat (5) @(posedge clk);
        axr(8'h08, cd, m, 2'h0);
        repeat (80) @(posedge clk);
        axr(8'h08, cd, m, 2'h0);
        for (i = 0; i < 4; i++)
        begin
            q = {th[i], tl[i], sh[i], sl[i]} & m[4*i +: 4];
            chk(32'(q), 32'(cd[4*i +: 4] & m[4*i +: 4]));
        end
        $display("test %s done", nm);
    endtask
    task automatic t_regs();
        axr(8'h0C, 32'h1, 32'hFFFFFFFF, 2'h0);
        axw(8'h08, 32'h0, 2'h2);
        axr(8'h14, 32'h0, 32'hFFFFFFFF, 2'h2);
        axr(8'h10, 32'h0, 32'hFFFFFFFF, 2'h0);
        axw(8'h0C, 32'h3, 2'h0);
        axr(8'h0C, 32'h3, 32'hFFFFFFFF, 2'h0);
        $display("test registers done");
    endtask
    task automatic t_over();
        up(1'b1);
        over <= 16'h0040;
        flt("over voltage", 32'h000F0010, 32'hFFFFFFFF);
        over <= 16'h0000;
    endtask
    task automatic t_sag();
        up(1'b1);
        sag <= 16'h0001;
        flt("under voltage", 32'h000F000B, 32'hFFFFFFFF);
        sag <= 16'h0000;
    endtask
    task automatic t_stuck();
        stuck <= 16'h2000;
        up(1'b0);
        flt("slow supply", 32'h000FE000, 32'hFFFFFFFF);
        stuck <= 16'h0000;
    endtask
    task automatic t_temp();
        up(1'b1);
        otmp <= 1'b1;
        flt("over temperature", 32'h000F0000, 32'hFFFFFFFF);
        chk(32'(oti), 32'h1);
        otmp <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(oti), 32'h0);
    endtask
    task automatic t_super();
        up(1'b1);
        svf <= 1'b1;
        flt("supervisor", 32'h000F0000, 32'hFFFFFFFF);
        svf <= 1'b0;
    endtask
    task automatic t_cmd();
        stuck <= 16'hFFFF;
        up(1'b0);
        turn_on <= 1'b0;
        flt("command drop", 32'h000F0004, 32'h000F000C);
        stuck <= 16'h0000;
        up(1'b1);
        turn_on <= 1'b0;
        repeat (5) @(posedge clk);
        turn_on <= 1'b1;
        flt("command in power-off", 32'h000F4444, 32'hFFFFFFFF);
    endtask
    task automatic t_show();
        int i;
        chk(32'(irq), 32'h0);
        axw(8'h0C, 32'h1, 2'h0);
        axw(8'h04, 32'h10, 2'h0);
        axw(8'h00, 32'h1F, 2'h0);
        up(1'b1);
        over <= 16'h0040;
        for (i = 0; i < 100 && shf !== 1'b1; i++)
            @(posedge clk);
        turn_on <= 1'b0;
        over <= 16'h0000;
        chk(32'({th, tl, sh, sl}), 32'h0);
        for (i = 0; i < 300 && sl !== 4'h2; i++)
            @(posedge clk);
        chk(32'({th, tl, sh, sl}), 32'h0002);
        chk(32'(irq), 32'h1);
        axw(8'h00, 32'h10, 2'h0);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("test restart display done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_over();
        t_sag();
        t_stuck();
        t_temp();
        t_super();
        t_cmd();
        t_show();
        conclude();
    end
endmodule // psf_top_tb
`default_nettype wire
